// file: logic/acs_pkg.sv
package acs_pkg;

    // apb byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_PINEN   = 8'h04;
    localparam logic [7:0] ADDR_RESULT  = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_MASK    = 8'h10;

    // control register fields
    localparam int CTRL_PU_BIT     = 0;
    localparam int CTRL_CONT_BIT   = 1;
    localparam int CTRL_RES10_BIT  = 2;
    localparam int CTRL_RJUST_BIT  = 3;
    localparam int CTRL_SIGNED_BIT = 4;
    localparam int CTRL_IE_BIT     = 5;
    localparam int CTRL_START_BIT  = 6;
    localparam int CTRL_CH_LSB     = 8;
    localparam int CTRL_W          = 11;

    localparam logic [10:0] CTRL_RESET = 11'h000;
    localparam logic [7:0]  PINEN_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // status/mask bit 0: conversion complete
    localparam int STAT_CC_BIT = 0;

    // timing
    localparam int PCLK_HZ      = 25_000_000;
    localparam int CONV_CLK_HZ  = 2_000_000;
    localparam int CONV_TIME_NS = 14_000;
    // conversion clock enable: every ceil(25/2) pclk cycles
    localparam int CONV_DIV = (PCLK_HZ + CONV_CLK_HZ - 1) / CONV_CLK_HZ;
    // conversion length in conversion clock ticks: 14.0 us * 2 MHz
    localparam int CONV_TICKS = CONV_TIME_NS * (CONV_CLK_HZ / 1_000_000)
                                / 1_000;

    typedef enum logic [1:0] {
        ACS_OFF  = 2'b00,
        ACS_IDLE = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_t;

    typedef struct packed {
        logic [2:0] channel;
        logic       start;
        logic       irq_en;
        logic       signed_fmt;
        logic       right_just;
        logic       res10;
        logic       continuous;
        logic       power_up;
    } acs_ctrl_t;

endpackage

// file: logic/acs_top.sv
`timescale 1ns/1ps
module acs_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        stop_mode,
    input  wire logic [9:0]  core_result,
    output logic      [2:0]  core_channel,
    output logic             core_analog_on,
    output logic             core_sample,
    output logic      [7:0]  analog_pin_en,
    output logic             irq
);

    acs_pkg::acs_ctrl_t   ctrl_reg,   ctrl_next;
    logic [7:0]           pinen_reg,  pinen_next;
    logic [15:0]          result_reg, result_next;
    logic                 stat_reg,   stat_next;
    logic                 mask_reg,   mask_next;
    acs_pkg::acs_state_t  state_reg,  state_next;
    logic [4:0]           div_reg,    div_next;
    logic [4:0]           tick_reg,   tick_next;
    logic                 start_req_reg, start_req_next;

    logic wr_en;
    logic rd_en;
    logic active;
    logic conv_en;
    logic done;
    logic rd_result;
    logic clr_status;

    // justify a raw 10-bit sample into the result register
    function automatic logic [15:0] fmt_result(
        input logic [9:0] raw,
        input logic       res10,
        input logic       rjust,
        input logic       sgn
    );
        logic [9:0] v;
        v = res10 ? raw : {raw[9:2], 2'b00};
        if (sgn) begin
            fmt_result = {~v[9], v[8:0], 6'b00_0000};
        end else if (rjust) begin
            fmt_result = res10 ? {6'b00_0000, v} : {8'h00, v[9:2]};
        end else begin
            fmt_result = {v, 6'b00_0000};
        end
    endfunction

    // register word to control fields; bit 7 is a spare hole
    function automatic acs_pkg::acs_ctrl_t word_to_ctrl(
        input logic [31:0] w
    );
        acs_pkg::acs_ctrl_t c;
        c.channel    = w[acs_pkg::CTRL_CH_LSB +: 3];
        c.start      = w[acs_pkg::CTRL_START_BIT];
        c.irq_en     = w[acs_pkg::CTRL_IE_BIT];
        c.signed_fmt = w[acs_pkg::CTRL_SIGNED_BIT];
        c.right_just = w[acs_pkg::CTRL_RJUST_BIT];
        c.res10      = w[acs_pkg::CTRL_RES10_BIT];
        c.continuous = w[acs_pkg::CTRL_CONT_BIT];
        c.power_up   = w[acs_pkg::CTRL_PU_BIT];
        word_to_ctrl = c;
    endfunction

    // read-back word; start is a pulse and always reads zero
    function automatic logic [31:0] ctrl_to_word(
        input acs_pkg::acs_ctrl_t c
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[acs_pkg::CTRL_CH_LSB +: 3] = c.channel;
        w[acs_pkg::CTRL_IE_BIT]      = c.irq_en;
        w[acs_pkg::CTRL_SIGNED_BIT]  = c.signed_fmt;
        w[acs_pkg::CTRL_RJUST_BIT]   = c.right_just;
        w[acs_pkg::CTRL_RES10_BIT]   = c.res10;
        w[acs_pkg::CTRL_CONT_BIT]    = c.continuous;
        w[acs_pkg::CTRL_PU_BIT]      = c.power_up;
        ctrl_to_word = w;
    endfunction

    // control value after reset, in field form
    localparam acs_pkg::acs_ctrl_t CTRL_INIT =
        word_to_ctrl(32'(acs_pkg::CTRL_RESET));

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // a result read counts as the acknowledge of the flag
    assign rd_result  = psel && penable && !pwrite &&
                        paddr == acs_pkg::ADDR_RESULT;
    assign clr_status = wr_en && paddr == acs_pkg::ADDR_STATUS &&
                        pwdata[acs_pkg::STAT_CC_BIT];

    assign active = ctrl_reg.power_up && !stop_mode;

    assign conv_en = active &&
                     (div_reg == 5'(acs_pkg::CONV_DIV - 1));

    assign done = (state_reg == acs_pkg::ACS_CONV) && conv_en &&
                  (tick_reg == 5'(acs_pkg::CONV_TICKS - 1));

    assign analog_pin_en  = pinen_reg;
    assign core_channel   = ctrl_reg.channel;
    assign core_analog_on = active;
    assign core_sample    = done;
    assign irq = stat_reg && mask_reg && ctrl_reg.irq_en;

    // register file; stays writable while powered down
    always_comb begin
        ctrl_next      = ctrl_reg;
        pinen_next     = pinen_reg;
        mask_next      = mask_reg;
        start_req_next = start_req_reg;
        ctrl_next.start = 1'b0;
        if (wr_en) begin
            case (paddr)
                acs_pkg::ADDR_CTRL: begin
                    ctrl_next = word_to_ctrl(pwdata);
                    ctrl_next.start = 1'b0;
                    if (pwdata[acs_pkg::CTRL_START_BIT]) begin
                        start_req_next = 1'b1;
                    end
                end
                acs_pkg::ADDR_PINEN: begin
                    pinen_next = pwdata[7:0];
                end
                acs_pkg::ADDR_MASK: begin
                    mask_next = pwdata[acs_pkg::STAT_CC_BIT];
                end
                default: begin
                end
            endcase
        end
        // a start only survives while the converter is powered and not converting
        if (!active || state_reg == acs_pkg::ACS_CONV) begin
            start_req_next = 1'b0;
        end
    end

    // conversion sequencer
    always_comb begin
        state_next  = state_reg;
        div_next    = div_reg;
        tick_next   = tick_reg;
        result_next = result_reg;
        stat_next   = stat_reg;
        // divider phase restarts at every power-up
        if (active) begin
            div_next = conv_en ? 5'd0 : div_reg + 5'd1;
        end else begin
            div_next = 5'd0;
        end
        case (state_reg)
            acs_pkg::ACS_OFF: begin
                tick_next = 5'd0;
                if (active) begin
                    state_next = acs_pkg::ACS_IDLE;
                end
            end
            acs_pkg::ACS_IDLE: begin
                tick_next = 5'd0;
                if (!active) begin
                    state_next = acs_pkg::ACS_OFF;
                end else if (start_req_reg) begin
                    state_next = acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_CONV: begin
                if (!active) begin
                    state_next = acs_pkg::ACS_OFF;
                    tick_next  = 5'd0;
                end else if (done) begin
                    tick_next = 5'd0;
                    result_next = fmt_result(core_result,
                                             ctrl_reg.res10,
                                             ctrl_reg.right_just,
                                             ctrl_reg.signed_fmt);
                    if (!ctrl_reg.continuous) begin
                        state_next = acs_pkg::ACS_IDLE;
                    end
                end else if (conv_en) begin
                    tick_next = tick_reg + 5'd1;
                end
            end
            default: begin
                state_next = acs_pkg::ACS_OFF;
                tick_next  = 5'd0;
            end
        endcase
        // write one clears; a completion in the same cycle wins
        if (clr_status) begin
            stat_next = 1'b0;
        end
        // reading the result also clears the flag, unless set again
        if (rd_result) begin
            stat_next = 1'b0;
        end
        if (done) begin
            stat_next = 1'b1;
        end
    end

    // read data registered in the setup phase
    logic [31:0] prdata_next;
    always_comb begin
        prdata_next = prdata;
        if (rd_en) begin
            case (paddr)
                acs_pkg::ADDR_CTRL:
                    prdata_next = ctrl_to_word(ctrl_reg);
                acs_pkg::ADDR_PINEN:
                    prdata_next = {24'h00_0000, pinen_reg};
                acs_pkg::ADDR_RESULT:
                    prdata_next = {16'h0000, result_reg};
                acs_pkg::ADDR_STATUS:
                    prdata_next = {29'h0, state_reg == acs_pkg::ACS_CONV,
                                   active, stat_reg};
                acs_pkg::ADDR_MASK:
                    prdata_next = {31'h0, mask_reg};
                default:
                    prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg      <= CTRL_INIT;
            pinen_reg     <= acs_pkg::PINEN_RESET;
            mask_reg      <= 1'b0;
            start_req_reg <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            pinen_reg     <= pinen_next;
            mask_reg      <= mask_next;
            start_req_reg <= start_req_next;
        end
    end

    // sequencer state; nothing is clocked off the divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= acs_pkg::RESULT_RESET;
            stat_reg   <= 1'b0;
            state_reg  <= acs_pkg::ACS_OFF;
            div_reg    <= 5'd0;
            tick_reg   <= 5'd0;
        end else begin
            result_reg <= result_next;
            stat_reg   <= stat_next;
            state_reg  <= state_next;
            div_reg    <= div_next;
            tick_reg   <= tick_next;
        end
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= prdata_next;
        end
    end

endmodule

// file: bench/acs_core_model.sv
`timescale 1ns/1ps
module acs_core_model (
    input  wire logic       pclk,
    input  wire logic [2:0] core_channel,
    input  wire logic       core_analog_on,
    output logic      [9:0] core_result
);
    logic [9:0] junk_reg = 10'h155;
    always @(posedge pclk) junk_reg <= ~junk_reg + 10'h001;
    // off core gives junk, not the last sample
    assign core_result = core_analog_on ?
        {core_channel, core_channel, core_channel, 1'b1} : junk_reg;
endmodule

// file: bench/acs_checker.sv
`timescale 1ns/1ps
module acs_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        stop_mode,
    input wire logic [2:0]  core_channel,
    input wire logic        core_analog_on,
    input wire logic        core_sample,
    input wire logic [7:0]  analog_pin_en,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       apb_wr;
    logic [9:0] gap_reg;
    logic [9:0] gap_next;
    assign apb_wr = psel && penable && pwrite;
    // gap counts powered cycles since last sample
    always_comb begin
        gap_next = gap_reg + 10'h001;
        if (!core_analog_on || core_sample) gap_next = 10'h000;
        else if (gap_reg == 10'h3ff) gap_next = gap_reg;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gap_reg <= 10'h000;
        else gap_reg <= gap_next;
    end
    AST_APB_READY: assert property (pready && !pslverr)
        else $error("apb answer not zero-wait okay");
    AST_SAMPLE_POWERED: assert property (
        core_sample |-> core_analog_on)
        else $error("sample while powered down");
    AST_STOP_OFF: assert property (stop_mode |-> !core_analog_on)
        else $error("analog on in stop");
    AST_SAMPLE_PULSE: assert property (core_sample |=> !core_sample)
        else $error("sample pulse too long");
    AST_CONV_LEN: assert property (core_sample |-> gap_reg >= 10'h168)
        else $error("conversion too short");
    AST_ON_CAUSE: assert property ($rose(core_analog_on) |->
        $past(apb_wr) || $past(stop_mode)) else $error("power up uncaused");
    AST_IRQ_CAUSE: assert property ($rose(irq) |->
        $past(core_sample) || $past(apb_wr)) else $error("irq uncaused");
    AST_CH_HOLD: assert property (!$stable(core_channel) |->
        $past(apb_wr)) else $error("channel moved alone");
    AST_PIN_HOLD: assert property (!$stable(analog_pin_en) |->
        $past(apb_wr)) else $error("pin select moved alone");
    AST_STOP_QUIET: assert property ($fell(stop_mode) |->
        !core_sample [*8]) else $error("sample after stop");
    cover property (core_sample && irq);
    cover property ($fell(stop_mode) && core_analog_on);
    cover property (core_sample ##1 !core_sample);
endmodule

// file: bench/acs_top_bench.sv
`timescale 1ns/1ps
module acs_top_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        stop_mode = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rng;
    logic        pready, pslverr, core_analog_on, core_sample, irq, seen;
    logic [9:0]  core_result, v;
    logic [2:0]  core_channel, ch;
    logic [7:0]  analog_pin_en;
    logic [31:0] exp_q[$];
    int          num_errors = 0;
    int          check_count = 0;
    always #20 pclk = ~pclk;
    acs_top i_acs_top (.*);
    acs_core_model i_acs_core_model (.*);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // read data is compared with the oldest note at the access edge
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            chk(prdata, exp_q.pop_front());
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wait_sample(input int n);
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++) begin
            @(negedge pclk);
            seen = (core_sample === 1'b1);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #800000;
        num_errors++;
        end_sim();
    end
    initial begin
        rng = 32'h0001_5db4;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
        rng = xs(rng);
        apb(1'b1, acs_pkg::ADDR_PINEN, rng);
        rd(acs_pkg::ADDR_PINEN, {24'h00_0000, rng[7:0]});
        chk(32'(analog_pin_en), {24'h00_0000, rng[7:0]});
        apb(1'b1, acs_pkg::ADDR_CTRL, 32'h0000_0040);
        wait_sample(400);
        chk(32'(seen), 32'h0000_0000);
        apb(1'b1, acs_pkg::ADDR_MASK, 32'h0000_0001);
        // four result formats, random channel each
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            ch = rng[2:0];
            v = {ch, ch, ch, 1'b1};
            apb(1'b1, acs_pkg::ADDR_CTRL, {21'h0, ch, 8'h21} | 32'(i * 4 + 4));
            apb(1'b1, acs_pkg::ADDR_CTRL, {21'h0, ch, 8'h61} | 32'(i * 4 + 4));
            chk(32'(core_channel), 32'(ch));
            wait_sample(500);
            chk(32'(seen), 32'h0000_0001);
            repeat (2) @(negedge pclk);
            chk(32'(irq), 32'h0000_0001);
            case (i)
                0: rd(acs_pkg::ADDR_RESULT, 32'(v) << 6);
                1: rd(acs_pkg::ADDR_RESULT, 32'(v[9:2]));
                2: rd(acs_pkg::ADDR_RESULT, 32'(v));
                default: rd(acs_pkg::ADDR_RESULT,
                            32'({~v[9], v[8:2], 8'h00}));
            endcase
            rd(acs_pkg::ADDR_STATUS, 32'h0000_0002);
        end
        apb(1'b1, acs_pkg::ADDR_MASK, 32'h0000_0000);
        apb(1'b1, acs_pkg::ADDR_CTRL, 32'h0000_0063);
        wait_sample(500);
        repeat (2) @(negedge pclk);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, acs_pkg::ADDR_STATUS, 32'h0000_0001);
        rd(acs_pkg::ADDR_STATUS, 32'h0000_0006);
        wait_sample(500);
        chk(32'(seen), 32'h0000_0001);
        repeat (100) @(posedge pclk);
        stop_mode <= 1'b1;
        repeat (50) @(posedge pclk);
        chk(32'(core_analog_on), 32'h0000_0000);
        stop_mode <= 1'b0;
        wait_sample(400);
        chk(32'(seen), 32'h0000_0000);
        chk(32'(core_analog_on), 32'h0000_0001);
        rd(acs_pkg::ADDR_STATUS, 32'h0000_0003);
        rd(acs_pkg::ADDR_CTRL, 32'h0000_0023);
        apb(1'b1, acs_pkg::ADDR_STATUS, 32'h0000_0001);
        apb(1'b1, acs_pkg::ADDR_CTRL, 32'h0000_0041);
        repeat (100) @(posedge pclk);
        apb(1'b1, acs_pkg::ADDR_CTRL, 32'h0000_0000);
        wait_sample(400);
        chk(32'(seen), 32'h0000_0000);
        rd(acs_pkg::ADDR_STATUS, 32'h0000_0000);
        apb(1'b1, acs_pkg::ADDR_CTRL, 32'h0000_0001);
        rd(acs_pkg::ADDR_STATUS, 32'h0000_0002);
        end_sim();
    end
endmodule
bind acs_top acs_checker i_acs_checker (.*);
